// ==== hw/bcsr_top.sv ====
`timescale 1ns/1ps
// read-only bus configuration register reached by alternate space loads
module bcsr_top
	import bcsr_pkg::*;
(
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire bcsr_req_t req_in, // one-cycle access request
	input wire bcsr_cfg_t cfg_in, // static chip configuration straps
	output logic hit_out, // access decodes to this register
	output logic rd_valid_out, // read data valid, one cycle
	output logic [63:0] rd_data_out // read data, registered
);
	logic [63:0] image; // current register image
	logic space_hit; // alternate space identifier matches
	logic vaddr_hit; // virtual address is the register's own
	logic is_read; // load rather than store
	logic is_super; // issued in supervisor mode
	logic addr_hit; // space and address match
	logic rd_take; // accepted supervisor read
	logic [63:0] rd_data_r; // held read data
	logic [63:0] rd_data_nxt;
	logic rd_valid_r;
	bcsr_cfg_t cfg_r; // configuration registered on every clock edge

	// timing of one access, as the core sees it:
	//   edge 0: request presented, hit_out follows it combinationally
	//   edge 1: a served load is taken, the word and the valid pulse are registered
	//   after edge 1: rd_valid_out high for this cycle only, rd_data_out holds the word
	// refused accesses run the same edges but leave both outputs alone, so a core
	// that wrongly issues a store here sees no change rather than a fault
	// there is no error response: traps for bad accesses belong to the load unit

	// image built from registered configuration so it is stable
	bcsr_pack u_pack
	(
		.cfg_in(cfg_r),
		.word_out(image)
	);

	// space and address are compared apart so each can be watched on its own
	assign space_hit = (req_in.space_id == BCSR_SPACE_ID);
	// all 64 address bits are compared; an alias at another offset would hide software bugs
	assign vaddr_hit = (req_in.vaddr == BCSR_VADDR);
	// load or store, and the privilege of the issuing thread
	assign is_read = !req_in.write;
	assign is_super = req_in.supervisor;
	// decode only the exact space and address
	assign addr_hit = req_in.valid && space_hit && vaddr_hit;
	// writes never reach storage; user-mode reads get no data
	assign rd_take = addr_hit && is_read && is_super;
	// the held word is replaced only by a served load
	assign rd_data_nxt = rd_take ? image : rd_data_r;
	assign hit_out = addr_hit;

	// strap capture: configuration is static, registered again on every clock edge
	// no reset here: straps are valid from power-up and a reset must not hide them
	always_ff @(posedge mclk_in)
	begin
		cfg_r <= cfg_in;
	end

	// read return path; reset drops any pending answer and clears the held word
	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			rd_valid_r <= 1'b0;
			rd_data_r <= BCSR_ZERO;
		end
		else
		begin
			rd_valid_r <= rd_take;
			rd_data_r <= rd_data_nxt;
		end
	end

	// both outputs come straight from flip-flops, so the core sees no decode glitches
	assign rd_valid_out = rd_valid_r;
	assign rd_data_out = rd_data_r;

	// checks on the returned word; each is written against the package layout,
	// not against the packing module, so a slip there shows up here
	// the top bits must read zero whatever the straps happen to carry
	a_rsvd_zero: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		rd_valid_out |-> rd_data_out[BCSR_DATA_W - 1:BCSR_RSVD_LSB] == '0) else $error("reserved bits nonzero");

	// the gap between ratio and target id is not a strap and must stay clear
	a_gap_zero: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		rd_valid_out |-> !rd_data_out[BCSR_GAP_BIT]) else $error("gap bit nonzero");

	// the reading thread sees its own target id in the low field
	a_read_resp: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		rd_take |=> rd_valid_out && rd_data_out[BCSR_INTERRUPT_TARGET_ID_LSB +: 10] == $past(cfg_r.interrupt_target_id))
		else $error("read lost");

	// a store is dropped: no answer, and the held word does not move
	a_write_ignored: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(req_in.valid && req_in.write) |=> !rd_valid_out && $stable(rd_data_out)) else $error("write acted");

	// user mode may not read the register, whatever the address
	a_user_blocked: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(req_in.valid && !req_in.supervisor) |=> !rd_valid_out) else $error("user read served");

	// a hit is only ever flagged for the register's own space and address
	a_decode_space: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		hit_out |-> req_in.space_id == BCSR_SPACE_ID && req_in.vaddr == BCSR_VADDR) else $error("bad decode");

	// cache size code and per-way flag sit in their own bits
	a_l2_fields: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		rd_take |=> rd_data_out[BCSR_L2SZ_LSB +: 3] == $past(cfg_r.l2_total_size_code)
			&& rd_data_out[BCSR_L2W_BIT] == $past(cfg_r.l2_way_size_flag)) else $error("l2 fields wrong");

	// ratio code is passed as strapped; reserved codes are not filtered here,
	// so software that sees one has a wrong strap, not a broken register
	a_clk_field: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		rd_take |=> rd_data_out[BCSR_CLK_LSB +: 5] == $past(cfg_r.clk_ratio_code)) else $error("ratio field wrong");

	// the packed image itself, watched every cycle and not only when read,
	// so a stray bit is caught even if no load happens to expose it
	a_image_layout: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		image[BCSR_DATA_W - 1:BCSR_RSVD_LSB] == '0 && !image[BCSR_GAP_BIT]) else $error("image layout wrong");

	// size code and target id land where the layout puts them; a swapped
	// slice in the packer would otherwise only show on a read of that field
	a_image_fields: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		image[BCSR_L2SZ_LSB +: 3] == cfg_r.l2_total_size_code
			&& image[BCSR_INTERRUPT_TARGET_ID_LSB +: 10] == cfg_r.interrupt_target_id) else $error("image fields wrong");

	// named steps of one access, shared by the properties below; they decode the
	// request from the raw fields again so the checks do not lean on addr_hit
	// a supervisor load of this register
	sequence s_sup_read;
		req_in.valid && !req_in.write && req_in.supervisor
			&& req_in.space_id == BCSR_SPACE_ID && req_in.vaddr == BCSR_VADDR;
	endsequence

	// a store or a user load aimed at the register: decoded, but never served
	sequence s_refused_hit;
		req_in.valid && (req_in.write || !req_in.supervisor)
			&& req_in.space_id == BCSR_SPACE_ID && req_in.vaddr == BCSR_VADDR;
	endsequence

	// an access to some other space or some other address
	sequence s_miss;
		req_in.valid && (req_in.space_id != BCSR_SPACE_ID || req_in.vaddr != BCSR_VADDR);
	endsequence

	// no request at all in this cycle
	sequence s_idle;
		!req_in.valid;
	endsequence

	// the one-cycle answer carrying the image built from the captured straps
	sequence s_answer;
		rd_valid_out && rd_data_out == $past(image);
	endsequence

	// nothing returned and the held word left as it was
	sequence s_quiet;
		!rd_valid_out && $stable(rd_data_out);
	endsequence

	// a served load answers exactly one cycle later with the whole word
	a_read_answer: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		s_sup_read |=> s_answer) else $error("read not answered");

	// refused accesses still decode, but the return path must stay silent
	a_refused_quiet: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		s_refused_hit |=> s_quiet) else $error("refused access answered");

	// a near miss, such as the next space or a high address bit, is ignored
	a_miss_quiet: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		s_miss |=> s_quiet) else $error("miss answered");

	// a miss must not raise the decode flag either
	a_miss_no_hit: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		s_miss |-> !hit_out) else $error("miss flagged as hit");

	// an idle cycle never produces an answer or disturbs the held word
	a_idle_quiet: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		s_idle |=> s_quiet) else $error("idle cycle answered");

	// the answer stands one cycle only; a caller polling rd_valid_out must not
	// expect it to linger
	a_answer_once: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(s_sup_read ##1 s_idle) |=> s_quiet) else $error("answer lingered");

	// back-to-back loads are legal and each gets its own answer pulse
	a_back_to_back: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(s_sup_read ##1 s_sup_read) |=> rd_valid_out && $past(rd_valid_out)) else $error("back-to-back read lost");

	// rd_valid_out never rises without a served load one cycle before
	a_valid_cause: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		rd_valid_out |-> $past(req_in.valid && !req_in.write && req_in.supervisor
			&& req_in.space_id == BCSR_SPACE_ID && req_in.vaddr == BCSR_VADDR)) else $error("answer without load");

	// every access at the register's space and address is flagged, in any mode
	a_hit_match: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(req_in.valid && req_in.space_id == BCSR_SPACE_ID && req_in.vaddr == BCSR_VADDR) |-> hit_out)
		else $error("hit not flagged");

	// hit_out is a decode of a live request only
	a_hit_valid: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		hit_out |-> req_in.valid) else $error("hit without request");

	// reset clears the return path; checked without disable so it is seen at all
	a_reset_clear: assert property (@(posedge mclk_in)
		sys_rst_in |=> !rd_valid_out && rd_data_out == BCSR_ZERO) else $error("reset left data");

	// the held word only moves on a served load; the first edge after reset is
	// skipped because reset itself zeroes the word
	a_data_hold: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(!$past(sys_rst_in) && !$past(rd_take)) |-> $stable(rd_data_out)) else $error("held word moved");
endmodule

// ==== inc/bcsr_pkg.sv ====
// package with layout, decode constants and carriers of the bus configuration register
package bcsr_pkg;
	localparam logic [7:0] BCSR_SPACE_ID = 8'h4a; // alternate space of the register
	localparam logic [63:0] BCSR_VADDR = 64'h0; // virtual address within that space
	localparam int BCSR_DATA_W = 64;
	localparam int BCSR_RSVD_LSB = 20; // bits 63:20 read zero
	localparam int BCSR_L2SZ_LSB = 17; // l2_total_size_code 19:17
	localparam int BCSR_L2W_BIT = 16; // l2_way_size_flag
	localparam int BCSR_CLK_LSB = 11; // clock ratio 15:11
	localparam int BCSR_GAP_BIT = 10; // reads zero
	localparam int BCSR_INTERRUPT_TARGET_ID_LSB = 0; // interrupt_target_id 9:0
	localparam logic [2:0] BCSR_L2_4MB = 3'h4;
	localparam logic [2:0] BCSR_L2_5MB = 3'h5;
	localparam logic [2:0] BCSR_L2_6MB = 3'h6;
	localparam logic [4:0] BCSR_RATIO_MIN = 5'h0c; // 3:1
	localparam logic [4:0] BCSR_RATIO_MAX = 5'h1e; // 7.5:1
	localparam logic [63:0] BCSR_ZERO = 64'h0;
	typedef struct packed {
		logic [2:0] l2_total_size_code;
		logic l2_way_size_flag;
		logic [4:0] clk_ratio_code;
		logic [9:0] interrupt_target_id;
	} bcsr_cfg_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic supervisor;
		logic [7:0] space_id;
		logic [63:0] vaddr;
	} bcsr_req_t;
endpackage

// ==== hw/bcsr_pack.sv ====
`timescale 1ns/1ps
// packs configuration fields into the 64-bit register image
module bcsr_pack
	import bcsr_pkg::*;
(
	input wire bcsr_cfg_t cfg_in,
	output logic [63:0] word_out
);
	// reserved and gap bits stay zero
	always_comb
	begin
		word_out = BCSR_ZERO;
		word_out[BCSR_L2SZ_LSB +: 3] = cfg_in.l2_total_size_code;
		word_out[BCSR_L2W_BIT] = cfg_in.l2_way_size_flag;
		word_out[BCSR_CLK_LSB +: 5] = cfg_in.clk_ratio_code;
		word_out[BCSR_INTERRUPT_TARGET_ID_LSB +: 10] = cfg_in.interrupt_target_id;
	end
endmodule

// ==== tb/bus_config_status_register_bench.sv ====
// self-checking bench of the bus configuration register
`timescale 1ns/1ps
module bus_config_status_register_bench;
	import bcsr_pkg::*;
	logic mclk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	bcsr_req_t req_in = '0;
	bcsr_cfg_t cfg_in = '{3'h5, 1'b1, 5'h0d, 10'h155}; // straps set before the first read
	logic hit_out;
	logic rd_valid_out;
	logic [63:0] rd_data_out;
	int fails = 0;
	int n_compared = 0;
	logic [63:0] held; // word the register should still show
	bcsr_top i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .req_in(req_in), .cfg_in(cfg_in),
		.hit_out(hit_out), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out));
	// clock of 5 ns
	initial
	begin
		forever #2.5 mclk_in = ~mclk_in;
	end
	// bench's own packing: top zeros, gap bit zero
	function automatic logic [63:0] img(input bcsr_cfg_t c);
		return {44'h0, c.l2_total_size_code, c.l2_way_size_flag, c.clk_ratio_code, 1'b0, c.interrupt_target_id};
	endfunction
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one access driven at a rising edge, taken at the next; answer looked at after it
	task automatic acc(input logic w, input logic s, input logic [7:0] sp, input logic [63:0] va);
		logic hit;
		hit = (sp == BCSR_SPACE_ID) && (va == BCSR_VADDR);
		@(posedge mclk_in);
		req_in <= '{1'b1, w, s, sp, va};
		#1 chk("hit_out", {63'h0, hit}, {63'h0, hit_out});
		@(posedge mclk_in);
		req_in.valid <= 1'b0;
		#1 chk("rd_valid_out", {63'h0, hit && s && !w}, {63'h0, rd_valid_out});
		chk("rd_data_out", held, rd_data_out);
	endtask
	// two supervisor loads on consecutive edges; each gets its own answer
	task automatic pair();
		@(posedge mclk_in);
		req_in <= '{1'b1, 1'b0, 1'b1, BCSR_SPACE_ID, BCSR_VADDR};
		@(posedge mclk_in);
		#1 chk("rd_valid_out", 64'h1, {63'h0, rd_valid_out});
		chk("rd_data_out", held, rd_data_out);
		@(posedge mclk_in);
		req_in.valid <= 1'b0;
		#1 chk("rd_valid_out", 64'h1, {63'h0, rd_valid_out});
		chk("rd_data_out", held, rd_data_out);
	endtask
	// reads over size, way, ratio boundaries and target id; straps settle one edge first
	task automatic s_read();
		bcsr_cfg_t c;
		for (int i = 0; i < 4; i++)
		begin
			c = '{BCSR_L2_4MB + 3'(i % 3), i[0], (i == 3) ? BCSR_RATIO_MAX : BCSR_RATIO_MIN + 5'(i), 10'h3ff - 10'(i)};
			@(posedge mclk_in);
			cfg_in <= c;
			held = img(c);
			acc(1'b0, 1'b1, BCSR_SPACE_ID, BCSR_VADDR);
			acc(1'b0, 1'b1, BCSR_SPACE_ID, BCSR_VADDR);
			pair();
		end
	endtask
	// write, user read, wrong space and address give nothing; data held
	task automatic s_refuse();
		acc(1'b1, 1'b1, BCSR_SPACE_ID, BCSR_VADDR);
		acc(1'b0, 1'b0, BCSR_SPACE_ID, BCSR_VADDR);
		acc(1'b0, 1'b1, 8'h4b, BCSR_VADDR);
		acc(1'b0, 1'b1, BCSR_SPACE_ID, 64'h8000000000000000);
		acc(1'b0, 1'b1, BCSR_SPACE_ID, BCSR_VADDR);
	endtask
	// reset in mid-run clears the word; a store after it leaves zero, a load refills it
	task automatic s_reset();
		@(posedge mclk_in);
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		#1 chk("rd_data_out", BCSR_ZERO, rd_data_out);
		chk("rd_valid_out", 64'h0, {63'h0, rd_valid_out});
		held = BCSR_ZERO;
		acc(1'b1, 1'b1, BCSR_SPACE_ID, BCSR_VADDR);
		held = img(cfg_in);
		acc(1'b0, 1'b1, BCSR_SPACE_ID, BCSR_VADDR);
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// reset for 16 cycles, then the scenarios
	initial
	begin
		repeat (16) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		#1 chk("rd_data_out", 64'h0, rd_data_out);
		chk("rd_valid_out", 64'h0, {63'h0, rd_valid_out});
		s_read();
		s_refuse();
		s_reset();
		conclude();
	end
endmodule
